// [design/bank_set_pkg.sv]
package bank_set_pkg;

  // ----------------------------------------------------------------
  // Organisation
  // ----------------------------------------------------------------
  localparam int NUM_BANKS = 8;
  localparam int NUM_SETS = 2;
  localparam int QUEUE_DEPTH = 4;
  localparam int WORD_W = 16;
  localparam int REQ_W = 12;
  localparam int GAP_CLASSES = 3;

  // ----------------------------------------------------------------
  // Request word field positions
  // ----------------------------------------------------------------
  localparam int OP_LSB = 9;
  localparam int BANK_LSB = 6;
  localparam int DELAY_LSB = 4;
  localparam int REF_EN_POS = 3;
  localparam int REF_BANK_LSB = 0;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_ROW_OPEN = 3'h1,
    OP_REFRESH_OPEN = 3'h2,
    OP_COL_WRITE = 3'h3,
    OP_COL_READ = 3'h4,
    OP_ROW_CLOSE = 3'h5
  } op_t;

  typedef logic [2:0] bank_t;
  typedef logic [1:0] delay_t;
  typedef logic [3:0] gap_t;
  typedef logic [WORD_W-1:0] word_t;

  // One pending row operation in a set's delay queue
  typedef struct packed {
    logic valid;
    logic open;
    bank_t bank;
  } row_slot_t;

  // ----------------------------------------------------------------
  // Spacing limits, counted in clock_period units of the link
  // ----------------------------------------------------------------
  localparam gap_t SAME_SET_ACTIVATE_GAP = 4'h4;
  localparam gap_t CROSS_SET_ACTIVATE_GAP = 4'h1;
  localparam gap_t SAME_SET_PRECHARGE_GAP = 4'h4;
  localparam gap_t CROSS_SET_PRECHARGE_GAP = 4'h1;
  localparam gap_t SAME_SET_WRITE_TO_READ_GAP = 4'h6;
  localparam gap_t CROSS_SET_WRITE_TO_READ_GAP = 4'h2;

  // Gap timer classes
  localparam int CLS_ACT = 0;
  localparam int CLS_PRE = 1;
  localparam int CLS_WR = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam gap_t GAP_RESET = 4'hf;
  localparam word_t WORD_RESET = 16'h0000;
  localparam logic [REQ_W-1:0] REQ_IDLE = 12'h000;

endpackage

// [design/request_link_if.sv]
interface request_link_if;
  import bank_set_pkg::*;

  // Link clock, made by the controller
  logic link_clk;
  // Request word, stable around the link's rising edge
  logic [REQ_W-1:0] request_lines;
  // Write data lane, valid with a column write request
  logic [WORD_W-1:0] write_lane;
  // Read data lane and its completion toggle
  logic [WORD_W-1:0] read_lane;
  logic read_toggle;

  modport controller (
    output link_clk,
    output request_lines,
    output write_lane,
    input read_lane,
    input read_toggle
  );

  modport device (
    input link_clk,
    input request_lines,
    input write_lane,
    output read_lane,
    output read_toggle
  );
endinterface

// [design/gap_timer.sv]
module gap_timer
  import bank_set_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic tick_in,
  input wire logic event_in,
  output logic [3:0] count_out
);

  typedef struct packed {
    gap_t count;
  } timer_state_t;

  timer_state_t s;
  timer_state_t next_s;

  // ----------------------------------------------------------------
  // Link slots since the last event, saturating
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    if (tick_in)
    begin
      if (event_in)
        next_s.count = 4'h1;
      else if (s.count != GAP_RESET)
        next_s.count = s.count + 4'h1;
    end
  end

  // State register
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      s.count <= GAP_RESET;
    else
      s <= next_s;
  end

  assign count_out = s.count;
endmodule

// [design/bank_set_controller.sv]
module bank_set_controller
  import bank_set_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic cmd_valid_in,
  input wire logic [2:0] cmd_op_in,
  input wire logic [2:0] cmd_bank_in,
  input wire logic [1:0] cmd_delay_in,
  input wire logic cmd_ref_en_in,
  input wire logic [2:0] cmd_ref_bank_in,
  input wire logic [15:0] cmd_wdata_in,
  output logic cmd_ready_out,
  output logic [15:0] rd_data_out,
  output logic rd_valid_out,
  request_link_if.controller link
);

  typedef struct packed {
    logic phase;
    logic [REQ_W-1:0] req;
    word_t wlane;
    logic [2:0] tog_sync;
    logic tog_seen;
    logic [1:0][WORD_W-1:0] data_sync;
    word_t rd_data;
    logic rd_valid;
  } ctl_state_t;

  ctl_state_t s;
  ctl_state_t next_s;
  gap_t cnt [GAP_CLASSES][NUM_SETS];
  logic slot;
  logic issue;
  logic spacing_ok;
  logic bank_set;
  logic ref_set;
  logic [GAP_CLASSES-1:0][NUM_SETS-1:0] ev;

  // Same-set and cross-set limits for one command class
  function automatic logic gap_ok(input gap_t same_cnt, input gap_t other_cnt, input gap_t same_gap,
                                  input gap_t cross_gap);
    gap_ok = (same_cnt >= same_gap) && (other_cnt >= cross_gap);
  endfunction

  // ----------------------------------------------------------------
  // Issue check
  // ----------------------------------------------------------------
  assign slot = s.phase;
  assign bank_set = cmd_bank_in[0];
  assign ref_set = cmd_ref_bank_in[0];

  // Spacing check against last write, activate and precharge per set
  always_comb
  begin
    spacing_ok = 1'b1;
    case (cmd_op_in)
      OP_ROW_OPEN, OP_REFRESH_OPEN:
        spacing_ok = gap_ok(cnt[CLS_ACT][bank_set], cnt[CLS_ACT][!bank_set],
                            SAME_SET_ACTIVATE_GAP, CROSS_SET_ACTIVATE_GAP);
      OP_ROW_CLOSE:
        spacing_ok = gap_ok(cnt[CLS_PRE][bank_set], cnt[CLS_PRE][!bank_set],
                            SAME_SET_PRECHARGE_GAP, CROSS_SET_PRECHARGE_GAP)
                     && (!cmd_ref_en_in || gap_ok(cnt[CLS_PRE][ref_set], cnt[CLS_PRE][!ref_set],
                            SAME_SET_PRECHARGE_GAP, CROSS_SET_PRECHARGE_GAP));
      OP_COL_READ:
        spacing_ok = gap_ok(cnt[CLS_WR][bank_set], cnt[CLS_WR][!bank_set],
                            SAME_SET_WRITE_TO_READ_GAP, CROSS_SET_WRITE_TO_READ_GAP);
      default:
        spacing_ok = 1'b1;
    endcase
  end

  assign cmd_ready_out = slot && spacing_ok;
  assign issue = cmd_valid_in && cmd_ready_out;

  // ----------------------------------------------------------------
  // Per-set event history
  // ----------------------------------------------------------------
  always_comb
  begin
    ev = '0;
    for (int st = 0; st < NUM_SETS; st++)
    begin
      ev[CLS_ACT][st] = issue && (cmd_op_in == OP_ROW_OPEN || cmd_op_in == OP_REFRESH_OPEN)
                        && (bank_set == st[0]);
      ev[CLS_PRE][st] = issue && (cmd_op_in == OP_ROW_CLOSE)
                        && ((bank_set == st[0]) || (cmd_ref_en_in && ref_set == st[0]));
      ev[CLS_WR][st] = issue && (cmd_op_in == OP_COL_WRITE) && (bank_set == st[0]);
    end
  end

  // One timer per class and set
  for (genvar g = 0; g < GAP_CLASSES * NUM_SETS; g++)
  begin : g_timer
    gap_timer u_timer (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .tick_in(slot),
      .event_in(ev[g / NUM_SETS][g % NUM_SETS]),
      .count_out(cnt[g / NUM_SETS][g % NUM_SETS])
    );
  end

  // ----------------------------------------------------------------
  // Link clock, request lines and read return
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.phase = !s.phase;
    next_s.rd_valid = 1'b0;
    if (slot)
    begin
      next_s.req = REQ_IDLE;
      if (issue)
      begin
        next_s.req[OP_LSB +: 3] = cmd_op_in;
        next_s.req[BANK_LSB +: 3] = cmd_bank_in;
        next_s.req[DELAY_LSB +: 2] = cmd_delay_in;
        next_s.req[REF_EN_POS] = cmd_ref_en_in;
        next_s.req[REF_BANK_LSB +: 3] = cmd_ref_bank_in;
        next_s.wlane = cmd_wdata_in;
      end
    end
    // Toggle takes one flop more than data, so data has settled
    next_s.tog_sync = {s.tog_sync[1:0], link.read_toggle};
    next_s.data_sync = {s.data_sync[0], link.read_lane};
    next_s.tog_seen = s.tog_sync[2];
    if (s.tog_sync[2] != s.tog_seen)
    begin
      next_s.rd_data = s.data_sync[1];
      next_s.rd_valid = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      s <= '0;
      s.req <= REQ_IDLE;
      s.wlane <= WORD_RESET;
      s.rd_data <= WORD_RESET;
    end
    else
      s <= next_s;
  end

  assign link.link_clk = s.phase;
  assign link.request_lines = s.req;
  assign link.write_lane = s.wlane;
  assign rd_data_out = s.rd_data;
  assign rd_valid_out = s.rd_valid;
endmodule

// [design/bank_set_device.sv]
module bank_set_device
  import bank_set_pkg::*;
(
  input wire logic sys_rst_in,
  output logic [7:0] bank_open_out,
  output logic [15:0] even_set_internal_bus_out,
  output logic [15:0] odd_set_internal_bus_out,
  request_link_if.device link
);

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [NUM_BANKS-1:0] open;
    logic [NUM_BANKS-1:0][WORD_W-1:0] word;
    row_slot_t [NUM_SETS-1:0][QUEUE_DEPTH-1:0] queue;
    logic [NUM_SETS-1:0][WORD_W-1:0] set_bus;
    logic [NUM_SETS-1:0] wr_pend;
    bank_t [NUM_SETS-1:0] wr_bank;
    logic rd_pend;
    logic rd_set;
    word_t rd_data;
    logic rd_toggle;
  } dev_state_t;

  dev_state_t s;
  dev_state_t next_s;
  logic rst;
  op_t op;
  bank_t bank;
  bank_t ref_bank;
  delay_t delay;
  logic ref_en;
  logic bank_set;
  logic ref_set;
  row_slot_t cmd_slot;
  row_slot_t ref_slot;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  assign rst = s.rst_sync[1];
  assign op = op_t'(link.request_lines[OP_LSB +: 3]);
  assign bank = link.request_lines[BANK_LSB +: 3];
  assign delay = link.request_lines[DELAY_LSB +: 2];
  assign ref_en = link.request_lines[REF_EN_POS];
  assign ref_bank = link.request_lines[REF_BANK_LSB +: 3];
  assign bank_set = bank[0];
  assign ref_set = ref_bank[0];

  // Row operations carried by this request
  always_comb
  begin
    cmd_slot = '0;
    ref_slot = '0;
    case (op)
      OP_ROW_OPEN, OP_REFRESH_OPEN:
      begin
        cmd_slot.valid = 1'b1;
        cmd_slot.open = 1'b1;
        cmd_slot.bank = bank;
      end
      OP_ROW_CLOSE:
      begin
        cmd_slot.valid = 1'b1;
        cmd_slot.bank = bank;
        ref_slot.valid = ref_en;
        ref_slot.bank = ref_bank;
      end
      default:
      begin
        cmd_slot = '0;
        ref_slot = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.rst_sync = {s.rst_sync[0], sys_rst_in};
    next_s.wr_pend = '0;
    next_s.rd_pend = 1'b0;

    // Per-set delay queues advance on their own
    for (int st = 0; st < NUM_SETS; st++)
    begin
      for (int d = 0; d < QUEUE_DEPTH - 1; d++)
        next_s.queue[st][d] = s.queue[st][d + 1];
      next_s.queue[st][QUEUE_DEPTH - 1] = '0;
      // Head of each set's queue acts on this edge
      if (s.queue[st][0].valid)
        next_s.open[s.queue[st][0].bank] = s.queue[st][0].open;
      // Write data lands in the bank a cycle after the bus
      if (s.wr_pend[st] && s.open[s.wr_bank[st]])
        next_s.word[s.wr_bank[st]] = s.set_bus[st];
    end

    // Immediate row operations, or parked by the delay field
    if (cmd_slot.valid)
    begin
      if (delay == 2'h0)
        next_s.open[cmd_slot.bank] = cmd_slot.open;
      else
        next_s.queue[bank_set][delay - 2'h1] = cmd_slot;
    end
    // Refresh close shares the packet's timing
    if (ref_slot.valid)
    begin
      if (delay == 2'h0)
        next_s.open[ref_slot.bank] = 1'b0;
      else
        next_s.queue[ref_set][delay - 2'h1] = ref_slot;
    end

    // Column operations onto the set's own bus
    if (op == OP_COL_WRITE)
    begin
      next_s.set_bus[bank_set] = link.write_lane;
      next_s.wr_pend[bank_set] = 1'b1;
      next_s.wr_bank[bank_set] = bank;
    end
    else if (op == OP_COL_READ)
    begin
      next_s.set_bus[bank_set] = s.word[bank];
      next_s.rd_pend = 1'b1;
      next_s.rd_set = bank_set;
    end

    // Transmit path samples whichever bus the read used
    if (s.rd_pend)
    begin
      next_s.rd_data = s.set_bus[s.rd_set];
      next_s.rd_toggle = !s.rd_toggle;
    end

    if (rst)
    begin
      next_s = '0;
      next_s.rst_sync = {s.rst_sync[0], sys_rst_in};
      next_s.rd_data = WORD_RESET;
    end
  end

  // State register on the link clock
  always_ff @(posedge link.link_clk)
  begin
    s <= next_s;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.read_lane = s.rd_data;
  assign link.read_toggle = s.rd_toggle;
  assign bank_open_out = s.open;
  assign even_set_internal_bus_out = s.set_bus[0];
  assign odd_set_internal_bus_out = s.set_bus[1];
endmodule

// [dv/bank_set_checker.sv]
module bank_set_checker
  import bank_set_pkg::*;
(
  input wire logic link_clk,
  input wire logic sys_rst_in,
  input wire logic [REQ_W-1:0] request_lines,
  input wire logic [WORD_W-1:0] write_lane,
  input wire logic [WORD_W-1:0] read_lane,
  input wire logic read_toggle
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------
  // Packet decoding
  // ------
  function automatic logic hit(logic [REQ_W-1:0] r, op_t o, logic s);
    return r[OP_LSB+:3] == o && r[BANK_LSB] == s;
  endfunction

  function automatic logic act(logic [REQ_W-1:0] r, logic s);
    return hit(r, OP_ROW_OPEN, s) || hit(r, OP_REFRESH_OPEN, s);
  endfunction

  function automatic logic pre(logic [REQ_W-1:0] r, logic s);
    return hit(r, OP_ROW_CLOSE, s) || (r[OP_LSB+:3] == OP_ROW_CLOSE && r[REF_EN_POS] && r[REF_BANK_LSB] == s);
  endfunction

  function automatic logic rd_any(logic [REQ_W-1:0] r);
    return r[OP_LSB+:3] == OP_COL_READ;
  endfunction

  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (sys_rst_in);

  // Read issued, then the toggle flips back
  sequence rd_issue;
    rd_any(request_lines);
  endsequence
  sequence toggle_back;
    ##[1:3] $changed(read_toggle);
  endsequence

  // ------
  // Spacing on the link
  // ------
  act_even_gap_a: assert property (act(request_lines, 1'b0) |=> (!act(request_lines, 1'b0)) [*3])
    else $error("even activates too close");
  act_odd_gap_a: assert property (act(request_lines, 1'b1) |=> (!act(request_lines, 1'b1)) [*3])
    else $error("odd activates too close");
  pre_even_gap_a: assert property (pre(request_lines, 1'b0) |=> (!pre(request_lines, 1'b0)) [*3])
    else $error("even precharges too close");
  pre_odd_gap_a: assert property (pre(request_lines, 1'b1) |=> (!pre(request_lines, 1'b1)) [*3])
    else $error("odd precharges too close");
  wr_rd_even_a: assert property (hit(request_lines, OP_COL_WRITE, 1'b0)
    |=> (!hit(request_lines, OP_COL_READ, 1'b0)) [*5])
    else $error("even read too soon after write");
  wr_rd_odd_a: assert property (hit(request_lines, OP_COL_WRITE, 1'b1)
    |=> (!hit(request_lines, OP_COL_READ, 1'b1)) [*5])
    else $error("odd read too soon after write");
  wr_rd_cross_a: assert property (request_lines[OP_LSB+:3] == OP_COL_WRITE
    |=> !(rd_any(request_lines) && request_lines[BANK_LSB] != $past(request_lines[BANK_LSB])))
    else $error("cross read too soon after write");
  read_return_a: assert property (rd_issue |-> toggle_back)
    else $error("read not returned");
  // Lanes move only with the packet or toggle that carries them
  read_lane_hold_a: assert property ($stable(read_toggle) |-> $stable(read_lane))
    else $error("read lane moved without toggle");
  write_lane_hold_a: assert property (request_lines == REQ_IDLE |-> $stable(write_lane))
    else $error("write lane moved without request");
endmodule

// [dv/bank_set_interleave_timing_tb.sv]
module bank_set_interleave_timing_tb
  import bank_set_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_in;
  logic ctl_rst;
  logic dev_rst;
  logic [28:0] cmd;
  logic ready;
  logic rd_valid;
  logic [15:0] rd_data;
  logic [7:0] bank_open;
  logic [15:0] even_bus;
  logic [15:0] odd_bus;
  int miscompares = 0;
  int comparisons = 0;
  int seed = 33;
  word_t mem [8];
  word_t expq [$];

  request_link_if link_bus();

  bank_set_controller bank_set_controller_inst (.clk_in(clk_in), .sys_rst_in(ctl_rst),
    .cmd_valid_in(cmd[28]), .cmd_op_in(cmd[27:25]), .cmd_bank_in(cmd[24:22]), .cmd_delay_in(cmd[21:20]),
    .cmd_ref_en_in(cmd[19]), .cmd_ref_bank_in(cmd[18:16]), .cmd_wdata_in(cmd[15:0]),
    .cmd_ready_out(ready), .rd_data_out(rd_data), .rd_valid_out(rd_valid), .link(link_bus.controller));
  bank_set_device bank_set_device_inst (.sys_rst_in(dev_rst), .bank_open_out(bank_open),
    .even_set_internal_bus_out(even_bus), .odd_set_internal_bus_out(odd_bus), .link(link_bus.device));
  bank_set_checker bank_set_checker_inst (.link_clk(link_bus.link_clk), .sys_rst_in(dev_rst),
    .request_lines(link_bus.request_lines), .write_lane(link_bus.write_lane),
    .read_lane(link_bus.read_lane), .read_toggle(link_bus.read_toggle));

  // ------
  // Clock, watchdog, checks
  // ------
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard, far beyond the expected run
  initial
  begin
    #2000000;
    miscompares++;
    end_of_test();
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_ge(input int got, input int lim);
    comparisons++;
    if (got < lim)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, lim);
    end
  endtask

  // Read results against oldest note
  always @(negedge clk_in)
  begin
    if (rd_valid === 1'b1)
      cmp(rd_data, expq.size() > 0 ? expq.pop_front() : 16'hxxxx);
  end

  // Request held until taken, then wire checked, and lane and set bus for writes
  task automatic issue(input op_t o, input bank_t b, input delay_t d, input logic re, input bank_t rb,
                       input word_t w, output int t, output logic [7:0] seen);
    int n;
    logic ok;
    n = 0;
    cmd <= {1'b1, o, b, d, re, rb, w};
    do
    begin
      @(negedge clk_in);
      ok = (ready === 1'b1);
      n++;
      @(posedge clk_in);
    end
    while (!ok && n < 200);
    // Request never taken
    if (!ok)
      miscompares++;
    t = int'($time / 100);
    cmd[28] <= 1'b0;
    @(negedge clk_in);
    seen = bank_open;
    cmp({4'h0, link_bus.request_lines}, {4'h0, o, b, d, re, rb});
    @(posedge clk_in);
    if (o == OP_COL_WRITE)
    begin
      cmp(link_bus.write_lane, w);
      @(negedge clk_in);
      cmp(b[0] ? odd_bus : even_bus, w);
      @(posedge clk_in);
    end
  endtask

  // ------
  // Main sequence
  // ------
  initial
  begin
    int tk [8];
    int t0;
    int t1;
    logic [7:0] s;
    cmd = '0;
    ctl_rst = 1'b1;
    dev_rst = 1'b1;
    repeat (20) @(posedge clk_in);
    ctl_rst <= 1'b0;
    repeat (10) @(posedge clk_in);
    dev_rst <= 1'b0;
    repeat (8) @(posedge clk_in);
    // Open all banks; bank 6 delayed one slot lands with bank 7
    for (int b = 0; b < 8; b++)
    begin
      issue(OP_ROW_OPEN, bank_t'(b), delay_t'(b == 6), 1'b0, 3'h0, 16'h0000, tk[b], s);
      if (b >= 2)
        cmp_ge(tk[b] - tk[b-2], 8);
    end
    cmp(16'(tk[1] - tk[0]), 16'h0002);
    cmp({8'h00, s}, 16'h003f);
    @(negedge clk_in);
    cmp({8'h00, bank_open}, 16'h00ff);
    @(posedge clk_in);
    // Fill every bank, then write even and read both sets
    for (int b = 0; b < 8; b++)
    begin
      mem[b] = word_t'($random(seed));
      issue(OP_COL_WRITE, bank_t'(b), 2'h0, 1'b0, 3'h0, mem[b], t0, s);
    end
    // Let the odd set's last fill write age past its same-set limit
    repeat (12) @(posedge clk_in);
    for (int b = 0; b < 8; b += 2)
    begin
      mem[b] = word_t'($random(seed));
      issue(OP_COL_WRITE, bank_t'(b), 2'h0, 1'b0, 3'h0, mem[b], t0, s);
      expq.push_back(mem[b+1]);
      issue(OP_COL_READ, bank_t'(b + 1), 2'h0, 1'b0, 3'h0, 16'h0000, t1, s);
      cmp(16'(t1 - t0), 16'h0004);
      expq.push_back(mem[b]);
      issue(OP_COL_READ, bank_t'(b), 2'h0, 1'b0, 3'h0, 16'h0000, t1, s);
      cmp_ge(t1 - t0, 12);
    end
    // Dual close packet, then same and cross set closes
    issue(OP_ROW_CLOSE, 3'h2, 2'h0, 1'b1, 3'h3, 16'h0000, t0, s);
    cmp({8'h00, s}, 16'h00ff);
    @(negedge clk_in);
    cmp({8'h00, bank_open}, 16'h00f3);
    @(posedge clk_in);
    issue(OP_ROW_CLOSE, 3'h4, 2'h0, 1'b0, 3'h0, 16'h0000, t1, s);
    cmp_ge(t1 - t0, 8);
    issue(OP_ROW_CLOSE, 3'h5, 2'h0, 1'b0, 3'h0, 16'h0000, t0, s);
    cmp(16'(t0 - t1), 16'h0002);
    issue(OP_ROW_CLOSE, 3'h0, 2'h1, 1'b0, 3'h0, 16'h0000, t1, s);
    issue(OP_ROW_CLOSE, 3'h1, 2'h0, 1'b0, 3'h0, 16'h0000, t0, s);
    cmp({8'h00, s}, 16'h00c3);
    @(negedge clk_in);
    cmp({8'h00, bank_open}, 16'h00c0);
    repeat (40) @(posedge clk_in);
    cmp(16'(expq.size()), 16'h0000);
    end_of_test();
  end
endmodule
